// >>> lncp_pkg.sv
package lncp_pkg;

	// ----------------------------------------
	// Register offsets on the register port
	// ----------------------------------------
	localparam logic [2:0] OFF_CONFIG = 3'h0;
	localparam logic [2:0] OFF_PTR_LOW = 3'h1;
	localparam logic [2:0] OFF_PTR_HIGH = 3'h2;
	localparam logic [2:0] OFF_DATA_LOW = 3'h3;
	localparam logic [2:0] OFF_DATA_HIGH = 3'h4;

	// ----------------------------------------
	// Configuration register fields
	// ----------------------------------------
	localparam int CFG_WIDE_BIT = 7;
	localparam int CFG_CHAIN_BIT = 6;
	localparam int CFG_DECODE_BIT = 5;
	localparam int CFG_TIMEOUT_HI = 4;
	localparam int CFG_TIMEOUT_LO = 3;
	localparam int CFG_WAIT_BIT = 2;
	localparam int CFG_IO_BIT = 1;
	localparam int CFG_TRANSMITTER_DISABLE_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'h1c;

	// ----------------------------------------
	// Pointer high register fields
	// ----------------------------------------
	localparam int PTRH_AUTOINC_BIT = 6;
	localparam int PTRH_ADDR_BITS = 3;

	// ----------------------------------------
	// Host address decode and wait timing
	// ----------------------------------------
	localparam int HOST_ADDR_W = 20;
	localparam int BLOCK_2K_LSB = 11;
	localparam int BLOCK_128K_LSB = 17;
	localparam int WAIT_CYCLES = 2;

endpackage

// >>> lncp_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Configuration bit 7 high runs the host data path 16 bits wide, low keeps it to bytes.
// - Configuration bit 6 high turns command chaining on, low keeps the older non-chaining behaviour.
// - With sequential I/O access, configuration bit 5 picks an 8K (low) or 16K (high) boot ROM window.
// - With memory mapping in wide mode, bit 5 picks a 128K (low) or 2K (high) block for the 16-bit chip-select; the ROM window enable blocks the 2K one.
// - Configuration bits 4 and 3 together set the extended response, idle and reconfiguration timeouts.
// - Configuration bit 2 high drops the host ready line for about two clocks per buffer access, one wait state.
// - Configuration bit 2 low gives zero-wait-state buffer accesses and drives the zero-wait-state output.
// - Configuration bit 1 high makes the buffer reachable only through the data ports, low makes it memory mapped.
// - Configuration bit 0 high disables the transmitter while the receiver keeps running.
// - The low pointer register holds the eight low buffer address bits.
// - The high pointer register holds the three top address bits in bits 2 to 0 and the auto increment enable in bit 6; other bits carry no meaning.
// - High pointer bit 6 with sequential access advances the pointer after every data port access, in wide mode only after the high data port.
// - The configuration register is read/write and loads 0x1c on hardware reset only.
// - In sequential mode the data ports read or write the buffer at the pointer address.
// - The pointer registers are not initialised by any reset.
module lncp_regs #(
	parameter int ADDR_W = 11
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Memory-mapped buffer port
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata,
	// Host pins
	input wire logic [lncp_pkg::HOST_ADDR_W-1:0] host_addr,
	input wire logic [lncp_pkg::HOST_ADDR_W-1:0] mem_base,
	input wire logic rom_window_enable_b,
	output logic mem_cs16_b,
	output logic iochrdy,
	output logic zero_wait_b,
	// Configuration outputs
	output logic wide_bus_enable,
	output logic chaining_enable,
	output logic rom_window_16k,
	output logic [1:0] timeout_extend_bits,
	output logic io_access,
	output logic transmitter_disable
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (ADDR_W != 8 + lncp_pkg::PTRH_ADDR_BITS) begin : g_bad_width
		$error("ADDR_W must equal the pointer width of 11");
	end

	localparam int DEPTH = 1 << ADDR_W;

	logic [7:0] cfg;
	logic [7:0] ptr_low;
	logic [7:0] ptr_high;
	logic [7:0] ram [DEPTH];
	logic [1:0] wait_cnt;
	logic [lncp_pkg::HOST_ADDR_W-1:0] addr_s1, addr_s2, base_s1, base_s2;
	logic rom_en_s1, rom_en_s2;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_data_port(input logic [2:0] a);
		return (a == lncp_pkg::OFF_DATA_LOW) || (a == lncp_pkg::OFF_DATA_HIGH);
	endfunction

	// Byte lane of a data port: in wide mode the pair forms one aligned word
	function automatic logic [ADDR_W-1:0] buf_index(input logic [2:0] a, input logic wide,
		input logic [ADDR_W-1:0] p);
		if (wide) begin
			return {p[ADDR_W-1:1], (a == lncp_pkg::OFF_DATA_HIGH)};
		end
		return p;
	endfunction

	logic [ADDR_W-1:0] ptr;
	logic data_wr, data_rd, data_acc, mem_ok, mem_acc, buf_acc, adv;
	logic [ADDR_W-1:0] step;
	logic [ADDR_W-1:0] next_ptr;
	logic [ADDR_W-1:0] data_idx;

	assign ptr = {ptr_high[lncp_pkg::PTRH_ADDR_BITS-1:0], ptr_low};
	assign data_wr = reg_wr && is_data_port(reg_addr) && io_access;
	assign data_rd = reg_rd && is_data_port(reg_addr) && io_access;
	assign data_acc = data_wr || data_rd;
	assign mem_ok = !io_access;
	assign mem_acc = (mem_wr || mem_rd) && mem_ok;
	assign buf_acc = data_acc || mem_acc;
	assign data_idx = buf_index(reg_addr, wide_bus_enable, ptr);

	// Wide mode advances once per word, after the high byte
	assign adv = data_acc && ptr_high[lncp_pkg::PTRH_AUTOINC_BIT]
		&& (!wide_bus_enable || reg_addr == lncp_pkg::OFF_DATA_HIGH);
	assign step = wide_bus_enable ? ADDR_W'(2) : ADDR_W'(1);
	assign next_ptr = ptr + step;

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Only the hardware reset pin reaches this register; a software reset leaves it alone
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= lncp_pkg::CFG_RESET;
		end else if (reg_wr && reg_addr == lncp_pkg::OFF_CONFIG) begin
			cfg <= reg_wdata;
		end
	end

	assign wide_bus_enable = cfg[lncp_pkg::CFG_WIDE_BIT];
	assign chaining_enable = cfg[lncp_pkg::CFG_CHAIN_BIT];
	assign timeout_extend_bits = cfg[lncp_pkg::CFG_TIMEOUT_HI:lncp_pkg::CFG_TIMEOUT_LO];
	assign io_access = cfg[lncp_pkg::CFG_IO_BIT];
	assign transmitter_disable = cfg[lncp_pkg::CFG_TRANSMITTER_DISABLE_BIT];
	// Window size only has meaning in sequential mode
	assign rom_window_16k = io_access && cfg[lncp_pkg::CFG_DECODE_BIT];

	// ----------------------------------------
	// Address pointer
	// ----------------------------------------
	// No reset: contents stay undefined until software writes them
	always_ff @(posedge core_clk) begin
		if (reg_wr && reg_addr == lncp_pkg::OFF_PTR_LOW) begin
			ptr_low <= reg_wdata;
		end else if (adv) begin
			ptr_low <= next_ptr[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reg_wr && reg_addr == lncp_pkg::OFF_PTR_HIGH) begin
			ptr_high <= reg_wdata;
		end else if (adv) begin
			ptr_high[lncp_pkg::PTRH_ADDR_BITS-1:0] <= next_ptr[ADDR_W-1:8];
		end
	end

	// ----------------------------------------
	// Buffer RAM
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (data_wr) begin
			ram[data_idx] <= reg_wdata;
		end else if (mem_wr && mem_ok) begin
			ram[mem_addr] <= mem_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_rdata <= 8'h00;
		end else if (mem_rd && mem_ok) begin
			mem_rdata <= ram[mem_addr];
		end else begin
			mem_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				lncp_pkg::OFF_CONFIG: reg_rdata <= cfg;
				lncp_pkg::OFF_PTR_LOW: reg_rdata <= ptr_low;
				lncp_pkg::OFF_PTR_HIGH: reg_rdata <= ptr_high;
				lncp_pkg::OFF_DATA_LOW, lncp_pkg::OFF_DATA_HIGH: begin
					reg_rdata <= io_access ? ram[data_idx] : 8'h00;
				end
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// Wait state and zero wait state
	// ----------------------------------------
	logic wait_start;
	assign wait_start = buf_acc && cfg[lncp_pkg::CFG_WAIT_BIT];

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_cnt <= 2'h0;
		end else if (wait_start) begin
			wait_cnt <= 2'(lncp_pkg::WAIT_CYCLES - 1);
		end else if (wait_cnt != 2'h0) begin
			wait_cnt <= wait_cnt - 2'h1;
		end
	end

	// Ready drops in the access cycle itself so the host sees it in time
	assign iochrdy = (wait_cnt == 2'h0) && !wait_start;
	assign zero_wait_b = !(buf_acc && !cfg[lncp_pkg::CFG_WAIT_BIT]);

	// ----------------------------------------
	// Host pin synchronisers and chip-select decode
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_s1 <= 20'h0_0000;
			addr_s2 <= 20'h0_0000;
			base_s1 <= 20'h0_0000;
			base_s2 <= 20'h0_0000;
			rom_en_s1 <= 1'b1;
			rom_en_s2 <= 1'b1;
		end else begin
			addr_s1 <= host_addr;
			addr_s2 <= addr_s1;
			base_s1 <= mem_base;
			base_s2 <= base_s1;
			rom_en_s1 <= rom_window_enable_b;
			rom_en_s2 <= rom_en_s1;
		end
	end

	logic hit_2k, hit_128k;
	assign hit_2k = addr_s2[lncp_pkg::HOST_ADDR_W-1:lncp_pkg::BLOCK_2K_LSB]
		== base_s2[lncp_pkg::HOST_ADDR_W-1:lncp_pkg::BLOCK_2K_LSB];
	assign hit_128k = addr_s2[lncp_pkg::HOST_ADDR_W-1:lncp_pkg::BLOCK_128K_LSB]
		== base_s2[lncp_pkg::HOST_ADDR_W-1:lncp_pkg::BLOCK_128K_LSB];

	// A ROM sharing the 2K window stays 8 bits wide, so its enable blocks the narrow decode
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_cs16_b <= 1'b1;
		end else if (!io_access && wide_bus_enable) begin
			if (cfg[lncp_pkg::CFG_DECODE_BIT]) begin
				mem_cs16_b <= !(hit_2k && rom_en_s2);
			end else begin
				mem_cs16_b <= !hit_128k;
			end
		end else begin
			mem_cs16_b <= 1'b1;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_cfg_write_read: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_CONFIG ##1 reg_rd && reg_addr == lncp_pkg::OFF_CONFIG
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("config readback differs from write");
	a_wide_from_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_CONFIG |=> wide_bus_enable == $past(reg_wdata[7]))
		else $error("wide bus enable not taken from bit 7");
	a_transmitter_disable_from_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_CONFIG |=> transmitter_disable == $past(reg_wdata[0]))
		else $error("transmitter disable not taken from bit 0");
	a_ptr_advance: assert property (
		adv |=> ptr == $past(ptr) + $past(step)) else $error("pointer did not advance by step");
	a_ptr_hold: assert property (
		data_acc && !ptr_high[lncp_pkg::PTRH_AUTOINC_BIT] |=> $stable(ptr))
		else $error("pointer moved without auto increment");
	a_ptr_spare_bits: assert property (
		adv |=> ptr_high[7:3] == $past(ptr_high[7:3])) else $error("advance touched spare bits");
	a_wait_length: assert property (
		wait_start |-> !iochrdy ##1 !iochrdy)
		else $error("wait state length wrong");
	a_wait_release: assert property (
		wait_start ##1 !wait_start ##1 !wait_start |-> iochrdy)
		else $error("ready not restored after wait state");
	a_zero_wait_out: assert property (
		buf_acc && !cfg[lncp_pkg::CFG_WAIT_BIT] |-> !zero_wait_b && iochrdy)
		else $error("zero wait state not signalled");
	a_mem_blocked_io: assert property (
		io_access && mem_rd |=> mem_rdata == 8'h00) else $error("memory port open in sequential mode");
	a_data_blocked_mem: assert property (
		!io_access && reg_rd && is_data_port(reg_addr) |=> reg_rdata == 8'h00)
		else $error("data port open in memory mode");

	// ----------------------------------------
	// Field and pointer checks
	// ----------------------------------------
	// Each config output follows its own bits one cycle after the write, the ROM window size also gated by bit 1
	a_chain_from_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_CONFIG |=> chaining_enable == $past(reg_wdata[6]))
		else $error("chaining enable not taken from bit 6");
	a_timeout_from_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_CONFIG |=> timeout_extend_bits == $past(reg_wdata[4:3]))
		else $error("timeout bits not taken from bits 4 and 3");
	a_io_from_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_CONFIG |=> io_access == $past(reg_wdata[1]))
		else $error("access mode not taken from bit 1");
	a_rom16k_from_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_CONFIG |=> rom_window_16k == ($past(reg_wdata[5]) && $past(reg_wdata[1])))
		else $error("rom window size wrong");
	a_cfg_hold: assert property (
		!(reg_wr && reg_addr == lncp_pkg::OFF_CONFIG) |=> $stable(cfg))
		else $error("config changed without a write");
	a_ptr_low_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_PTR_LOW |=> ptr_low == $past(reg_wdata))
		else $error("pointer low write lost");
	a_ptr_high_write: assert property (
		reg_wr && reg_addr == lncp_pkg::OFF_PTR_HIGH |=> ptr_high == $past(reg_wdata))
		else $error("pointer high write lost");
	a_wide_pairing: assert property (
		data_acc && wide_bus_enable |-> data_idx[0] == (reg_addr == lncp_pkg::OFF_DATA_HIGH))
		else $error("wide data port byte lane wrong");
	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_mem_rdata_idle: assert property (
		!mem_rd |=> mem_rdata == 8'h00)
		else $error("memory read data outside its cycle");
	a_zero_wait_idle: assert property (
		!buf_acc |-> zero_wait_b)
		else $error("zero wait state without an access");
	a_cs16_narrow: assert property (
		io_access || !wide_bus_enable |=> mem_cs16_b)
		else $error("chip-select in narrow or sequential mode");
	// The 2K decode must stay off while the ROM shares the window
	a_cs16_rom_block: assert property (
		!io_access && wide_bus_enable && cfg[lncp_pkg::CFG_DECODE_BIT] && !rom_en_s2 |=> mem_cs16_b)
		else $error("chip-select while rom window enabled");
	a_cs16_128k: assert property (
		!io_access && wide_bus_enable && !cfg[lncp_pkg::CFG_DECODE_BIT] && hit_128k |=> !mem_cs16_b)
		else $error("chip-select missing in 128K block");

	c_seq_autoinc: cover property (adv ##1 adv);
	c_wait_access: cover property (wait_start ##2 iochrdy);
	c_cs16_2k: cover property (!mem_cs16_b && cfg[lncp_pkg::CFG_DECODE_BIT]);
	c_ptr_wrap: cover property (adv && ptr == {ADDR_W{1'b1}});
	c_wide_word: cover property (data_wr && wide_bus_enable ##2 data_wr && wide_bus_enable);

endmodule
`default_nettype wire

// >>> lncp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host model on the register port
// ----------------------------------------
module lncp_host (
	// Clock
	input wire logic core_clk,
	// Register port
	output logic [2:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Wait state pins
	input wire logic iochrdy,
	input wire logic zero_wait_b
);
	logic rdy_acc;
	logic rdy_next;
	logic zw_acc;
	logic [7:0] rd_val;
	initial begin
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One strobe cycle; timeout bits are left to software, same on all nodes
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(negedge core_clk);
		rdy_acc = iochrdy;
		zw_acc = zero_wait_b;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// Released data does not keep the last value
		reg_wdata <= ~d;
		@(negedge core_clk);
		rd_val = reg_rdata;
		rdy_next = iochrdy;
	endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] ra;
	logic [7:0] rwd, rrd, mrd;
	logic rw, rr, mw, mr, cs_b, rdy, zw_b, wide, chn, r16, io, txo;
	logic [1:0] tout;
	logic [10:0] ma = 11'h000;
	logic [7:0] mwd = 8'h00;
	logic [19:0] ha = 20'h0_0000;
	logic [19:0] mb = 20'hA_5800;
	logic romb = 1'b1;
	int mismatches = 0;
	int checked = 0;
	always #2.5 core_clk = ~core_clk;
	initial begin
		mw = 1'b0;
		mr = 1'b0;
	end
	lncp_host u_host (.core_clk(core_clk), .reg_addr(ra), .reg_wdata(rwd), .reg_wr(rw), .reg_rd(rr),
		.reg_rdata(rrd), .iochrdy(rdy), .zero_wait_b(zw_b));
	lncp_regs #(.ADDR_W(11)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(ra), .reg_wdata(rwd),
		.reg_wr(rw), .reg_rd(rr), .reg_rdata(rrd), .mem_addr(ma), .mem_wdata(mwd), .mem_wr(mw),
		.mem_rd(mr), .mem_rdata(mrd), .host_addr(ha), .mem_base(mb), .rom_window_enable_b(romb),
		.mem_cs16_b(cs_b), .iochrdy(rdy), .zero_wait_b(zw_b), .wide_bus_enable(wide),
		.chaining_enable(chn), .rom_window_16k(r16), .timeout_extend_bits(tout), .io_access(io),
		.transmitter_disable(txo));
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		u_host.acc(1'b1, a, d);
	endtask
	task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
		u_host.acc(1'b0, a, 8'h00);
		chk(n, u_host.rd_val, e);
	endtask
	task automatic mem(input logic w, input logic [10:0] a, input logic [7:0] d);
		@(posedge core_clk);
		ma <= a;
		mwd <= d;
		mw <= w;
		mr <= !w;
		@(posedge core_clk);
		mw <= 1'b0;
		mr <= 1'b0;
		@(negedge core_clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_cfg();
		logic [7:0] v[10] = '{8'h80, 8'h40, 8'h22, 8'h20, 8'h08, 8'h10, 8'h02, 8'h01, 8'hff, 8'h00};
		rdc("cfg_rst", lncp_pkg::OFF_CONFIG, lncp_pkg::CFG_RESET);
		chk("out_rst", {1'b0, wide, chn, r16, tout, io, txo}, 8'h0c);
		foreach (v[i]) begin
			wr(lncp_pkg::OFF_CONFIG, v[i]);
			chk("cfg_out", {1'b0, wide, chn, r16, tout, io, txo}, {1'b0, v[i][7:6], v[i][5] & v[i][1], v[i][4:3], v[i][1:0]});
			rdc("cfg_rd", lncp_pkg::OFF_CONFIG, v[i]);
		end
		wr(3'h5, 8'h5a);
		rdc("unmapped", 3'h5, 8'h00);
		rdc("cfg_keep", lncp_pkg::OFF_CONFIG, 8'h00);
	endtask
	task automatic t_wrap();
		wr(lncp_pkg::OFF_CONFIG, 8'h06);
		wr(lncp_pkg::OFF_PTR_LOW, 8'hff);
		wr(lncp_pkg::OFF_PTR_HIGH, 8'hc7);
		wr(lncp_pkg::OFF_DATA_LOW, 8'ha5);
		chk("rdy_acc", {7'h00, u_host.rdy_acc}, 8'h00);
		chk("rdy_next", {7'h00, u_host.rdy_next}, 8'h00);
		@(negedge core_clk);
		chk("rdy_after", {7'h00, rdy}, 8'h01);
		rdc("wrap_lo", lncp_pkg::OFF_PTR_LOW, 8'h00);
		rdc("wrap_hi", lncp_pkg::OFF_PTR_HIGH, 8'hc0);
		wr(lncp_pkg::OFF_PTR_HIGH, 8'h07);
		wr(lncp_pkg::OFF_PTR_LOW, 8'hff);
		rdc("top_byte", lncp_pkg::OFF_DATA_LOW, 8'ha5);
		rdc("no_adv", lncp_pkg::OFF_PTR_LOW, 8'hff);
		wr(lncp_pkg::OFF_CONFIG, 8'h02);
		rdc("zw_byte", lncp_pkg::OFF_DATA_LOW, 8'ha5);
		chk("zw_acc", {6'h00, u_host.zw_acc, u_host.rdy_acc}, 8'h01);
	endtask
	task automatic t_wide();
		wr(lncp_pkg::OFF_CONFIG, 8'h86);
		wr(lncp_pkg::OFF_PTR_LOW, 8'h10);
		wr(lncp_pkg::OFF_PTR_HIGH, 8'h40);
		wr(lncp_pkg::OFF_DATA_LOW, 8'h11);
		wr(lncp_pkg::OFF_DATA_HIGH, 8'h22);
		rdc("word_adv", lncp_pkg::OFF_PTR_LOW, 8'h12);
		wr(lncp_pkg::OFF_CONFIG, 8'h06);
		wr(lncp_pkg::OFF_PTR_LOW, 8'h10);
		rdc("byte0", lncp_pkg::OFF_DATA_LOW, 8'h11);
		rdc("byte1", lncp_pkg::OFF_DATA_LOW, 8'h22);
	endtask
	task automatic t_mem();
		wr(lncp_pkg::OFF_CONFIG, 8'h00);
		mem(1'b1, 11'h005, 8'haa);
		mem(1'b0, 11'h005, 8'h00);
		chk("mem_rd", mrd, 8'haa);
		rdc("port_off", lncp_pkg::OFF_DATA_LOW, 8'h00);
		wr(lncp_pkg::OFF_CONFIG, 8'h02);
		mem(1'b0, 11'h005, 8'h00);
		chk("mem_off", mrd, 8'h00);
	endtask
	task automatic t_cs();
		logic [7:0] c[7] = '{8'h80, 8'h80, 8'ha0, 8'ha0, 8'ha0, 8'h20, 8'ha2};
		logic [19:0] a[7] = '{20'hA_0000, 20'hC_0000, 20'hA_5FFF, 20'hA_5FFF, 20'hA_6000, 20'hA_5FFF, 20'hA_5FFF};
		logic [6:0] rb = 7'b1101011;
		logic [6:0] e = 7'b0110111;
		foreach (c[i]) begin
			wr(lncp_pkg::OFF_CONFIG, c[i]);
			@(posedge core_clk);
			ha <= a[i];
			romb <= rb[6-i];
			// Pins pass two sync stages and an output register
			repeat (4) @(posedge core_clk);
			@(negedge core_clk);
			chk("cs16_b", {7'h00, cs_b}, {7'h00, e[6-i]});
		end
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		t_cfg();
		t_wrap();
		t_wide();
		t_mem();
		t_cs();
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
